// *** rtl/dac_ctrl_pkg.sv ***
/*
  constants shared by both ends of the dac control link: frame layout,
  register addresses, control fields, reset values, link timing and the
  wishbone map of the host end.
  assumes a 100 mhz system clock on both ends.
*/
`default_nettype none
package dac_ctrl_pkg;
  localparam int FRAME_BITS = 24;
  localparam int DATA_BITS = 20;
  localparam logic [4:0] FRAME_LEN = 5'h18;
  localparam int RW_POS = 23;
  localparam int ADDR_MSB = 22;
  localparam int ADDR_LSB = 20;

  localparam logic [2:0] ADDR_DAC_DATA = 3'h1;
  localparam logic [2:0] ADDR_CONTROL = 3'h2;
  localparam logic [2:0] ADDR_CLEAR_VALUE = 3'h3;
  localparam logic [2:0] ADDR_SOFT_PULSE = 3'h4;

  localparam int SOFT_LOAD_POS = 0;
  localparam int SOFT_CLEAR_POS = 1;
  localparam int SOFT_RESET_POS = 2;

  localparam int CTL_FB_SELECT_POS = 1;
  localparam int CTL_HIGH_Z_POS = 2;
  localparam int CTL_GROUND_POS = 3;
  localparam int CTL_OFFSET_BIN_POS = 4;
  localparam int CTL_LIN_LSB = 6;
  localparam int LIN_W = 4;

  localparam logic [3:0] LIN_SPAN_10V = 4'h0;
  localparam logic [3:0] LIN_SPAN_10_12V = 4'h9;
  localparam logic [3:0] LIN_SPAN_12_16V = 4'ha;
  localparam logic [3:0] LIN_SPAN_16_19V = 4'hb;
  localparam logic [3:0] LIN_SPAN_19_20V = 4'hc;

  localparam logic [19:0] DAC_DATA_RST = 20'h00000;
  localparam logic [19:0] CONVERTER_RST = 20'h00000;
  localparam logic [19:0] CLEAR_VALUE_RST = 20'h00000;
  localparam logic [19:0] CONTROL_RST = 20'h0000c;

  localparam int SYS_CLK_PERIOD_NS = 10;
  localparam int LINK_HALF_PERIOD_NS = 40;
  localparam int LINK_HALF_CYCLES =
    (LINK_HALF_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

  localparam logic [7:0] WB_FRAME_DATA = 8'h00;
  localparam logic [7:0] WB_COMMAND = 8'h04;
  localparam logic [7:0] WB_STATUS = 8'h08;
  localparam logic [7:0] WB_READBACK = 8'h0c;
  localparam logic [7:0] WB_PINS = 8'h10;
  localparam logic [1:0] PINS_RST = 2'h3;
endpackage : dac_ctrl_pkg
`default_nettype wire

// *** rtl/dac_link_if.sv ***
/*
  serial link and strobe pins between the host controller and the dac.
  assumes both ends run on their own sys_clk; no clocking here.
*/
`default_nettype none
interface dac_link_if;
  logic sclk;
  logic sync_n;
  logic sdin;
  logic sdo;
  logic output_load_n;
  logic output_clear_n;

  modport host (
    output sclk,
    output sync_n,
    output sdin,
    output output_load_n,
    output output_clear_n,
    input sdo
  );

  modport device (
    input sclk,
    input sync_n,
    input sdin,
    input output_load_n,
    input output_clear_n,
    output sdo
  );
endinterface : dac_link_if
`default_nettype wire

// *** rtl/dac_clear_and_output_control.sv ***
/*
  device end: takes 24-bit frames off the link, holds dac data, control,
  clear value and the write-only pulse register, and drives the converter
  word and output state.
  assumes the link pins are asynchronous to sys_clk and that sclk stays
  at most one edge per four sys_clk cycles.
*/
// Chosen here: the register addresses and register access over Wishbone.
// Behaviour
// - clear pin or bit loads clear value
// - clear value resets to zero
// - pulse register write-only, acts like pin
// - address 100: reset, clear, load bits
// - soft clear ignored while load pin low
// - soft load ignored while clear pin low
// - soft load moves pending data to converter
// - soft clear copies clear value to converter
// - soft reset returns to power-on state
// - power-on reset restores all register defaults
// - power-on: tristate and ground clamp
// - host clears both bits before use
// - normal mode shows held code, reset zero
// - clamp dominates, tristate alone high impedance
// - linearity field resets to 0000
// - feedback select one: unity gain
// - feedback select zero: gain of two
// - intermediate linearity codes for wider spans
// - frame top bit: zero write, one read
`default_nettype none
module dac_clear_and_output_control
  import dac_ctrl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  dac_link_if.device link,
  output logic [19:0] dac_code,
  output logic out_normal,
  output logic out_high_impedance,
  output logic out_ground_clamp,
  output logic feedback_resistor_select,
  output logic offset_binary,
  output logic [3:0] lin_comp
);

  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_d;
    logic sync_s1;
    logic sync_s2;
    logic sync_d;
    logic sdin_s1;
    logic sdin_s2;
    logic load_s1;
    logic load_s2;
    logic clr_s1;
    logic clr_s2;
    logic [4:0] bit_cnt;
    logic [23:0] in_sh;
    logic [23:0] out_sh;
    logic [23:0] rd_word;
    logic [19:0] dac_data;
    logic [19:0] converter;
    logic [19:0] control;
    logic [19:0] clear_value;
    logic out_normal;
    logic out_high_z;
    logic out_ground;
  } dev_state_t;

  localparam dev_state_t ST_RST = '{
    sync_s1: 1'b1, sync_s2: 1'b1, sync_d: 1'b1,
    load_s1: 1'b1, load_s2: 1'b1, clr_s1: 1'b1, clr_s2: 1'b1,
    dac_data: DAC_DATA_RST,
    converter: CONVERTER_RST,
    control: CONTROL_RST,
    clear_value: CLEAR_VALUE_RST,
    out_ground: 1'b1,
    default: '0
  };

  dev_state_t st_ff;
  dev_state_t nxt_st;

  logic sclk_rise;
  logic sclk_fall;
  logic sync_fall;
  logic sync_rise;
  logic frame_on;
  logic [19:0] f_data;
  logic [2:0] f_addr;
  logic f_read;
  logic ctl_ground;
  logic ctl_high_z;

  // edges seen only on second stage, never on the first
  assign sclk_rise = st_ff.sclk_s2 & ~st_ff.sclk_d;
  assign sclk_fall = ~st_ff.sclk_s2 & st_ff.sclk_d;
  assign sync_fall = ~st_ff.sync_s2 & st_ff.sync_d;
  assign sync_rise = st_ff.sync_s2 & ~st_ff.sync_d;
  assign frame_on = ~st_ff.sync_s2;
  assign f_data = st_ff.in_sh[DATA_BITS-1:0];
  assign f_addr = st_ff.in_sh[ADDR_MSB:ADDR_LSB];
  assign f_read = st_ff.in_sh[RW_POS];

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sclk_s1 = link.sclk;
    nxt_st.sclk_s2 = st_ff.sclk_s1;
    nxt_st.sclk_d = st_ff.sclk_s2;
    nxt_st.sync_s1 = link.sync_n;
    nxt_st.sync_s2 = st_ff.sync_s1;
    nxt_st.sync_d = st_ff.sync_s2;
    nxt_st.sdin_s1 = link.sdin;
    nxt_st.sdin_s2 = st_ff.sdin_s1;
    nxt_st.load_s1 = link.output_load_n;
    nxt_st.load_s2 = st_ff.load_s1;
    nxt_st.clr_s1 = link.output_clear_n;
    nxt_st.clr_s2 = st_ff.clr_s1;

    // readback word of the previous read frame goes out in this one
    if (sync_fall) begin
      nxt_st.bit_cnt = 5'h00;
      nxt_st.out_sh = st_ff.rd_word;
    end
    if (frame_on && sclk_rise) begin
      nxt_st.in_sh = {st_ff.in_sh[FRAME_BITS-2:0], st_ff.sdin_s2};
      // saturates at 31, so a long frame never reads as 24
      if (!(&st_ff.bit_cnt)) begin
        nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
      end
    end
    if (frame_on && sclk_fall) begin
      nxt_st.out_sh = {st_ff.out_sh[FRAME_BITS-2:0], 1'b0};
    end

    // pins act as levels; a held clear pin wins over a held load pin.
    // set before the commit, so an ungated soft pulse would show for a cycle
    if (!st_ff.clr_s2) begin
      nxt_st.converter = st_ff.clear_value;
    end else if (!st_ff.load_s2) begin
      nxt_st.converter = st_ff.dac_data;
    end

    // short or long frames are dropped whole
    if (sync_rise && st_ff.bit_cnt == FRAME_LEN) begin
      if (f_read) begin
        nxt_st.rd_word = {1'b1, f_addr, 20'h00000};
        case (f_addr)
          ADDR_DAC_DATA: nxt_st.rd_word[DATA_BITS-1:0] = st_ff.dac_data;
          ADDR_CONTROL: nxt_st.rd_word[DATA_BITS-1:0] = st_ff.control;
          ADDR_CLEAR_VALUE: nxt_st.rd_word[DATA_BITS-1:0] = st_ff.clear_value;
          default: nxt_st.rd_word[DATA_BITS-1:0] = 20'h00000;
        endcase
      end else begin
        case (f_addr)
          ADDR_DAC_DATA: nxt_st.dac_data = f_data;
          // linearity, feedback select, coding and output bits live here
          ADDR_CONTROL: nxt_st.control = f_data;
          ADDR_CLEAR_VALUE: nxt_st.clear_value = f_data;
          ADDR_SOFT_PULSE: begin
            if (f_data[SOFT_RESET_POS]) begin
              // synchronisers are left alone so the link stays in step
              nxt_st.dac_data = DAC_DATA_RST;
              nxt_st.converter = CONVERTER_RST;
              nxt_st.control = CONTROL_RST;
              nxt_st.clear_value = CLEAR_VALUE_RST;
              nxt_st.rd_word = '0;
            end else if (f_data[SOFT_CLEAR_POS] && st_ff.load_s2) begin
              nxt_st.converter = st_ff.clear_value;
            end else if (f_data[SOFT_LOAD_POS] && st_ff.clr_s2) begin
              nxt_st.converter = st_ff.dac_data;
            end
          end
          default: nxt_st.rd_word = st_ff.rd_word;
        endcase
      end
    end

    // clamp wins over tristate
    ctl_ground = nxt_st.control[CTL_GROUND_POS];
    ctl_high_z = nxt_st.control[CTL_HIGH_Z_POS];
    nxt_st.out_ground = ctl_ground;
    nxt_st.out_high_z = ctl_high_z & ~ctl_ground;
    nxt_st.out_normal = ~ctl_high_z & ~ctl_ground;
  end

  // reset constant: clamp and tristate set in control, other words zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.sdo = st_ff.out_sh[FRAME_BITS-1];
  // converter word drives dac_code in every output state, clamp and tristate included
  assign dac_code = st_ff.converter;
  assign out_normal = st_ff.out_normal;
  assign out_high_impedance = st_ff.out_high_z;
  assign out_ground_clamp = st_ff.out_ground;
  assign feedback_resistor_select = st_ff.control[CTL_FB_SELECT_POS];
  assign offset_binary = st_ff.control[CTL_OFFSET_BIN_POS];
  assign lin_comp = st_ff.control[CTL_LIN_LSB +: LIN_W];

endmodule : dac_clear_and_output_control
`default_nettype wire

// *** rtl/dac_link_host.sv ***
/*
  host end: wishbone classic slave that builds 24-bit frames on the link,
  captures the word shifted back, and drives the load and clear pins.
  assumes sdo is asynchronous and the device answers one frame later.
*/
`default_nettype none
module dac_link_host
  import dac_ctrl_pkg::*;
#(
  parameter int HALF_CYCLES = LINK_HALF_CYCLES
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  dac_link_if.host link
);

  // readback bit must be settled through the device and both synchronisers
  if (HALF_CYCLES < 4 || HALF_CYCLES > 255) begin : g_bad_half
    $error("HALF_CYCLES must lie in 4..255");
  end

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_SHIFT = 4'b0010,
    H_TAIL = 4'b0100,
    H_GAP = 4'b1000
  } host_fsm_t;

  typedef struct packed {
    host_fsm_t fsm;
    logic ack;
    logic [31:0] rdata;
    logic [19:0] frame_data;
    logic [3:0] command;
    logic [23:0] readback;
    logic [1:0] pins;
    logic [23:0] sh_out;
    logic [4:0] bit_cnt;
    logic [7:0] div;
    logic sclk;
    logic sync_n;
    logic sdo_s1;
    logic sdo_s2;
  } host_state_t;

  localparam host_state_t ST_RST = '{
    fsm: H_IDLE, pins: PINS_RST, sync_n: 1'b1, default: '0
  };
  localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_val[8*i +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  host_state_t st_ff;
  host_state_t nxt_st;
  logic req;
  logic busy;
  logic [31:0] merged;

  assign req = wb_cyc_i & wb_stb_i & ~st_ff.ack;
  assign busy = (st_ff.fsm != H_IDLE);

  always_comb begin
    nxt_st = st_ff;
    merged = 32'h00000000;
    nxt_st.sdo_s1 = link.sdo;
    nxt_st.sdo_s2 = st_ff.sdo_s1;
    nxt_st.ack = req;
    nxt_st.rdata = 32'h00000000;
    if (req && wb_we_i) begin
      case (wb_adr_i)
        WB_FRAME_DATA: begin
          merged = merge_bytes({12'h000, st_ff.frame_data}, wb_dat_i, wb_sel_i);
          nxt_st.frame_data = merged[DATA_BITS-1:0];
        end
        WB_COMMAND: begin
          // a command while a frame runs is dropped
          if (!busy && wb_sel_i[0]) begin
            nxt_st.command = wb_dat_i[3:0];
            nxt_st.sh_out = {wb_dat_i[3:0], st_ff.frame_data};
            nxt_st.fsm = H_SHIFT;
            nxt_st.sync_n = 1'b0;
            nxt_st.sclk = 1'b0;
            nxt_st.div = 8'h00;
            nxt_st.bit_cnt = 5'h00;
          end
        end
        WB_PINS: begin
          merged = merge_bytes({30'h00000000, st_ff.pins}, wb_dat_i, wb_sel_i);
          nxt_st.pins = merged[1:0];
        end
        default: nxt_st.pins = st_ff.pins;
      endcase
    end else if (req) begin
      case (wb_adr_i)
        WB_FRAME_DATA: nxt_st.rdata = {12'h000, st_ff.frame_data};
        WB_COMMAND: nxt_st.rdata = {28'h0000000, st_ff.command};
        WB_STATUS: nxt_st.rdata = {31'h00000000, busy};
        WB_READBACK: nxt_st.rdata = {8'h00, st_ff.readback};
        WB_PINS: nxt_st.rdata = {30'h00000000, st_ff.pins};
        default: nxt_st.rdata = 32'h00000000;
      endcase
    end

    // sclk derived here: high after one half, data moves on the fall
    case (st_ff.fsm)
      H_IDLE: nxt_st.div = 8'h00;
      H_SHIFT: begin
        nxt_st.div = st_ff.div + 8'h01;
        if (st_ff.div == HALF_LAST) begin
          nxt_st.div = 8'h00;
          if (!st_ff.sclk) begin
            nxt_st.sclk = 1'b1;
          end else begin
            nxt_st.sclk = 1'b0;
            nxt_st.readback = {st_ff.readback[FRAME_BITS-2:0], st_ff.sdo_s2};
            nxt_st.sh_out = {st_ff.sh_out[FRAME_BITS-2:0], 1'b0};
            nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
            if (st_ff.bit_cnt == FRAME_LEN - 5'h01) begin
              nxt_st.fsm = H_TAIL;
            end
          end
        end
      end
      H_TAIL, H_GAP: begin
        nxt_st.div = st_ff.div + 8'h01;
        if (st_ff.div == HALF_LAST) begin
          nxt_st.div = 8'h00;
          nxt_st.sync_n = 1'b1;
          nxt_st.fsm = (st_ff.fsm == H_TAIL) ? H_GAP : H_IDLE;
        end
      end
      default: nxt_st = ST_RST;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_ack_o = st_ff.ack;
  assign wb_dat_o = st_ff.rdata;
  assign link.sclk = st_ff.sclk;
  assign link.sync_n = st_ff.sync_n;
  assign link.sdin = st_ff.sh_out[FRAME_BITS-1];
  assign link.output_load_n = st_ff.pins[0];
  assign link.output_clear_n = st_ff.pins[1];

endmodule : dac_link_host
`default_nettype wire

// *** dv/dac_link_chk.sv ***
/*
  checker of the serial link between host and dac ends.
  assumes the default sclk half period of 4 sys_clk cycles.
*/
`default_nettype none
module dac_link_chk (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  input wire logic sdo,
  input wire logic output_load_n,
  input wire logic output_clear_n
);
  logic sclk_ff;
  logic [4:0] rises_ff;
  logic [4:0] nxt_rises;
  always_comb begin
    nxt_rises = sync_n ? 5'h0 : rises_ff + {4'h0, sclk & ~sclk_ff};
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_ff <= 1'b0;
      rises_ff <= 5'h0;
    end else begin
      sclk_ff <= sclk;
      rises_ff <= nxt_rises;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  idle_low_a: assert property (sync_n |-> !sclk)
    else $error("sclk moves outside a frame");
  high_len_a: assert property ($rose(sclk) |-> sclk[*4])
    else $error("sclk high phase too short");
  low_len_a: assert property ($fell(sclk) |-> !sclk[*4])
    else $error("sclk low phase too short");
  frame_lead_a: assert property ($fell(sync_n) |-> !sclk[*4] ##1 sclk)
    else $error("first sclk rise misplaced");
  bit_count_a: assert property ($rose(sync_n) |-> rises_ff == 5'h18)
    else $error("frame not 24 bits");
  rise_cap_a: assert property (sclk && !sclk_ff |-> rises_ff < 5'h18)
    else $error("more than 24 sclk rises");
  frame_gap_a: assert property ($rose(sync_n) |-> sync_n[*4])
    else $error("gap between frames too short");
  sdin_hold_a: assert property (!sync_n && !$past(sync_n) && !$fell(sclk)
    |-> $stable(sdin))
    else $error("sdin moved away from sclk fall");
  sdo_idle_a: assert property (sync_n |-> !sdo)
    else $error("sdo not fully shifted out between frames");
endmodule : dac_link_chk
`default_nettype wire

// *** dv/dac_clear_and_output_control_tb.sv ***
/*
  bench joining host and dac ends; software orders over wishbone.
  assumes 100 mhz sys_clk and the package's register map.
*/
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module dac_clear_and_output_control_tb
  import dac_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, arst_n, cyc, stb, we, ack, nrm, hz, gnd, fb, ob;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q, rng;
  logic [3:0] sel, lin;
  logic [19:0] code, d, c, e;
  logic [3:0] lc [5] = '{LIN_SPAN_10V, LIN_SPAN_10_12V, LIN_SPAN_12_16V,
    LIN_SPAN_16_19V, LIN_SPAN_19_20V};
  int n_mismatch = 0, checks = 0, cycles = 0;
  logic watch = 1'b0;
  logic [19:0] keep;
  int glitch = 0;
  // a pin-held code must not blink while a gated soft pulse commits
  always @(posedge sys_clk) begin
    if (watch && code !== keep) begin
      glitch++;
    end
  end
  dac_link_if link();
  dac_link_host u_dac_link_host (.sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_ack_o(ack), .wb_dat_o(rdat), .link(link));
  dac_clear_and_output_control u_dac_clear_and_output_control (.sys_clk(sys_clk),
    .arst_n(arst_n), .link(link), .dac_code(code), .out_normal(nrm),
    .out_high_impedance(hz), .out_ground_clamp(gnd), .feedback_resistor_select(fb),
    .offset_binary(ob), .lin_comp(lin));
  dac_link_chk u_chk (.sys_clk(sys_clk), .arst_n(arst_n), .sclk(link.sclk),
    .sync_n(link.sync_n), .sdin(link.sdin), .sdo(link.sdo),
    .output_load_n(link.output_load_n), .output_clear_n(link.output_clear_n));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  // expected {normal, high_z, clamp}: clamp dominates
  function automatic logic [2:0] st(input logic t, input logic g);
    return {~t & ~g, t & ~g, g};
  endfunction : st
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  // no fixed answer time assumed: waits for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= dt;
    do @(posedge sys_clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic frame(input logic r, input logic [2:0] a, input logic [19:0] v);
    wb(1'b1, WB_FRAME_DATA, {12'h0, v});
    wb(1'b1, WB_COMMAND, {28'h0, r, a});
    q = 32'h1;
    while (q[0] !== 1'b0) wb(1'b0, WB_STATUS, 32'h0);
    repeat (4) @(negedge sys_clk);
  endtask : frame
  task automatic pins(input logic [1:0] p);
    wb(1'b1, WB_PINS, {30'h0, p});
    repeat (4) @(negedge sys_clk);
  endtask : pins
  task automatic rnd();
    rng = xs(rng);
    d = rng[19:0];
  endtask : rnd
  task automatic rdback(input logic [2:0] a, input logic [19:0] v);
    wb(1'b0, WB_READBACK, 32'h0);
    `CHK("readback", {1'b1, a, v}, q[23:0])
  endtask : rdback
  task automatic rst_state();
    `CHK("defaults", {20'h0, 3'b001, 6'h0}, {code, nrm, hz, gnd, fb, ob, lin})
  endtask : rst_state
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    arst_n = 1'b0;
    {cyc, stb, we, adr, wdat} = '0;
    sel = 4'hf;
    rng = 32'h533bfb17;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(negedge sys_clk);
    rst_state();
    frame(1'b1, ADDR_CLEAR_VALUE, 20'h0);
    frame(1'b1, ADDR_CLEAR_VALUE, 20'h0);
    rdback(ADDR_CLEAR_VALUE, 20'h0);
    for (int i = 0; i < 8; i++) begin
      frame(1'b0, ADDR_CONTROL, {10'h0, lc[i % 5], 1'b0, i[2], i[1], i[0], i[0] ^ i[1], 1'b0});
      `CHK("state", st(i[0], i[1]), {nrm, hz, gnd})
      `CHK("fb", i[0] ^ i[1], fb)
      `CHK("lin", lc[i % 5], lin)
      `CHK("ob", i[2], ob)
    end
    frame(1'b0, ADDR_CONTROL, 20'h0);
    `CHK("normal", {20'h0, 3'b100}, {code, nrm, hz, gnd})
    e = 20'h0;
    // data waits in its register until a load
    repeat (3) begin
      rnd();
      frame(1'b0, ADDR_DAC_DATA, d);
      `CHK("pending", e, code)
      frame(1'b0, ADDR_SOFT_PULSE, 20'h1);
      e = d;
      `CHK("load", e, code)
    end
    // the second read frame clocks the dac data word out on sdo
    frame(1'b1, ADDR_DAC_DATA, 20'h0);
    frame(1'b1, ADDR_CONTROL, 20'h0);
    rdback(ADDR_DAC_DATA, e);
    rnd();
    c = d;
    frame(1'b0, ADDR_CLEAR_VALUE, c);
    frame(1'b1, ADDR_CLEAR_VALUE, 20'h0);
    frame(1'b1, ADDR_SOFT_PULSE, 20'h0);
    rdback(ADDR_CLEAR_VALUE, c);
    frame(1'b0, ADDR_CONTROL, 20'h0);
    rdback(ADDR_SOFT_PULSE, 20'h0);
    frame(1'b0, ADDR_SOFT_PULSE, 20'h2);
    `CHK("soft_clear", c, code)
    rnd();
    frame(1'b0, ADDR_DAC_DATA, d);
    pins(2'b10);
    `CHK("load_pin", d, code)
    keep = d;
    watch = 1'b1;
    frame(1'b0, ADDR_SOFT_PULSE, 20'h2);
    watch = 1'b0;
    `CHK("clr_blocked", d, code)
    `CHK("clr_glitch", 0, glitch)
    pins(2'b01);
    `CHK("clear_pin", c, code)
    rnd();
    frame(1'b0, ADDR_DAC_DATA, d);
    keep = c;
    watch = 1'b1;
    frame(1'b0, ADDR_SOFT_PULSE, 20'h1);
    watch = 1'b0;
    pins(2'b11);
    `CHK("ld_blocked", c, code)
    `CHK("ld_glitch", 0, glitch)
    frame(1'b0, ADDR_SOFT_PULSE, 20'h4);
    rst_state();
    frame(1'b0, ADDR_CONTROL, 20'h0);
    frame(1'b0, ADDR_SOFT_PULSE, 20'h2);
    `CHK("clr_reset", 20'h0, code)
    finish_test();
  end
endmodule : dac_clear_and_output_control_tb
`default_nettype wire
